/* File: test/usx_alu_assertions.sv */
// checker for the packed exchange and halving alu
`timescale 1ns/10ps
module usx_alu_checker (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rstn,
  // watched ports
  input wire usx_pkg::usx_issue_type issue,
  input wire usx_pkg::usx_wb_type    wb
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [16:0] dLo, sHi, sLo, sBh, sLx, dHi;
  logic [35:0] expAs;
  logic [35:0] expSa;
  logic [31:0] expH16;
  // 17-bit lanes so carry and borrow survive into flags and halves
  assign dLo = {1'b0, issue.firstOperand[15:0]} - issue.secondOperand[31:16];
  assign sHi = {1'b0, issue.firstOperand[31:16]} + issue.secondOperand[15:0];
  assign sLo = {1'b0, issue.firstOperand[15:0]} + issue.secondOperand[15:0];
  assign sBh = {1'b0, issue.firstOperand[31:16]} + issue.secondOperand[31:16];
  assign expAs = {{2{sHi[16]}}, {2{~dLo[16]}}, sHi[15:0], dLo[15:0]};
  assign expH16 = {sBh[16:1], sLo[16:1]};
  // sub-add exchange: low lane sums, high lane subtracts
  assign sLx = {1'b0, issue.firstOperand[15:0]} + issue.secondOperand[31:16];
  assign dHi = {1'b0, issue.firstOperand[31:16]} - issue.secondOperand[15:0];
  assign expSa = {{2{~dHi[16]}}, {2{sLx[16]}}, dHi[15:0], sLx[15:0]};
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_exec;
    issue.valid && issue.condPass;
  endsequence
  sequence s_op(o);
    s_exec ##0 (issue.op == o);
  endsequence
  AST_LATENCY: assert property (s_exec |=> wb.regWrite)
    else $error("executed op gave no write");
  AST_REFUSE: assert property (!(issue.valid && issue.condPass) |=>
    !wb.regWrite && !wb.geWrite && $stable(wb.regData)) else $error("refused op wrote");
  AST_EXCH_AS: assert property (s_op(8'h01) |=>
    {wb.geFlags, wb.regData} == $past(expAs)) else $error("exchange add-sub wrong");
  AST_EXCH_SA: assert property (s_op(8'h02) |=>
    {wb.geFlags, wb.regData} == $past(expSa)) else $error("exchange sub-add wrong");
  AST_HALF16: assert property (s_op(8'h04) |=>
    wb.regData == $past(expH16) && !wb.geWrite) else $error("halving add wrong");
  AST_GE_HOLD: assert property (!wb.geWrite |-> $stable(wb.geFlags))
    else $error("flags moved without write");
  AST_GE_EXCH: assert property (wb.geWrite |-> wb.regWrite &&
    $past(issue.op[1:0]) != 2'h0) else $error("flag write from halving op");
  AST_DEST: assert property (s_exec ##0 !issue.hasDest |=>
    wb.regIdx == $past(issue.firstReg)) else $error("omitted target wrong");
  AST_TARGET: assert property (s_exec ##0 issue.hasDest |=>
    wb.regIdx == $past(issue.destReg)) else $error("named target wrong");
endmodule
bind usx_alu usx_alu_checker chkr (.core_clk(core_clk), .rstn(rstn), .issue(issue), .wb(wb));

/* File: test/usx_alu_bench.sv */
// self-checking bench for the packed exchange and halving alu
`timescale 1ns/10ps
module usx_alu_bench;
  logic                   core_clk = 1'b0;
  logic                   rstn     = 1'b0;
  usx_pkg::usx_issue_type issue    = '0;
  usx_pkg::usx_wb_type    wb;
  int                     n_fail   = 0;
  int                     compares = 0;
  int                     cyc      = 0;
  logic [31:0]            held;
  ////////////////////////////////////////////////////////////////////////////////
  always #25 core_clk = ~core_clk;
  usx_alu uut (.core_clk(core_clk), .rstn(rstn), .issue(issue), .wb(wb));
  usx_regfile_model rf (.core_clk(core_clk), .wb(wb));
  // lanes kept 17 bits wide so the halving shift keeps carry and borrow
  function automatic logic [16:0] ad(logic [15:0] x, logic [15:0] y);
    return {1'b0, x} + {1'b0, y};
  endfunction
  function automatic logic [16:0] sb(logic [15:0] x, logic [15:0] y);
    return {1'b0, x} - {1'b0, y};
  endfunction
  function automatic logic [31:0] expWord(logic [7:0] op, logic [31:0] a, logic [31:0] b);
    logic [16:0] p;
    logic [16:0] q;
    p = 17'h0;
    q = 17'h0;
    case (op)
      8'h01, 8'h10: begin p = ad(a[31:16], b[15:0]); q = sb(a[15:0], b[31:16]); end
      8'h02, 8'h20: begin p = sb(a[31:16], b[15:0]); q = ad(a[15:0], b[31:16]); end
      8'h04: begin p = ad(a[31:16], b[31:16]); q = ad(a[15:0], b[15:0]); end
      8'h40: begin p = sb(a[31:16], b[31:16]); q = sb(a[15:0], b[15:0]); end
      default: ;
    endcase
    expWord = (op[1:0] != 2'h0) ? {p[15:0], q[15:0]} : {p[16:1], q[16:1]};
    for (int i = 0; i < 4; i++) begin
      if (op[3] | op[7]) begin
        p = op[3] ? ad(16'(a[8*i+:8]), 16'(b[8*i+:8])) : sb(16'(a[8*i+:8]), 16'(b[8*i+:8]));
        expWord[8*i+:8] = p[8:1];
      end
    end
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one issue at a falling edge; result is settled one falling edge later
  task automatic run(logic [7:0] op, logic [31:0] a, logic [31:0] b, logic cp, logic hd);
    @(negedge core_clk);
    issue.valid = 1'b1;
    issue.op = usx_pkg::usx_op_type'(op);
    issue.condPass = cp;
    issue.hasDest = hd;
    issue.destReg = 4'h2;
    issue.firstReg = 4'h5;
    issue.firstOperand = a;
    issue.secondOperand = b;
    @(negedge core_clk);
    issue.valid = 1'b0;
  endtask
  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_exch;
    run(8'h01, 32'hffff0003, 32'h00040001, 1'b1, 1'b1);
    chk(wb.regData, 32'h0000ffff);
    chk({28'h0, wb.geFlags}, 32'hc);
    run(8'h02, 32'h0001ffff, 32'h00010002, 1'b1, 1'b1);
    chk(wb.regData, 32'hffff0000);
    chk({28'h0, wb.geFlags}, 32'h3);
    chk({31'h0, wb.geWrite}, 32'h1);
  endtask
  task automatic t_halve;
    for (int j = 0; j < 2; j++) begin
      for (int i = 2; i < 8; i++) begin
        run(8'h01 << i, j ? 32'hffff0181 : 32'h0001ff80, j ? 32'h0001ff80 : 32'hffff0181, 1'b1, 1'b1);
        chk(wb.regData, expWord(8'h01 << i, issue.firstOperand, issue.secondOperand));
        chk({27'h0, wb.geWrite, wb.geFlags}, 32'h3);
      end
    end
  endtask
  task automatic t_cond;
    held = wb.regData;
    run(8'h01, 32'h0, 32'h00010000, 1'b0, 1'b1);
    chk({31'h0, wb.regWrite}, 32'h0);
    chk(wb.regData, held);
    chk({27'h0, wb.geWrite, wb.geFlags}, 32'h3);
  endtask
  task automatic t_dest;
    run(8'h04, 32'h00040006, 32'h00020002, 1'b1, 1'b0);
    chk({28'h0, wb.regIdx}, 32'h5);
    run(8'h04, 32'h0, 32'h0, 1'b1, 1'b1);
    chk({28'h0, wb.regIdx}, 32'h2);
    chk(rf.regs[5], 32'h00030004);
    chk(32'(rf.nBad), 32'h0);
  endtask
  // hang guard well above the roughly forty cycles the tests take
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    t_exch();
    t_halve();
    t_cond();
    t_dest();
    final_report();
  end
endmodule

/* File: test/usx_regfile_model.sv */
// register file model on the far side of the write-back
`timescale 1ns/10ps
module usx_regfile_model (
  // clock
  input wire logic                core_clk,
  // write-back from the alu
  input wire usx_pkg::usx_wb_type wb
);
  logic [31:0] regs [16];
  int          nBad = 0;
  // only executed results land; stimulus never names sp or pc
  always @(posedge core_clk) begin
    if (wb.regWrite === 1'b1) begin
      regs[wb.regIdx] <= wb.regData;
      nBad <= nBad + int'(wb.badReg);
    end
  end
endmodule

/* File: verilog/usx_alu.sv */
// unsigned packed exchange and halving alu slice with registered write-back
`timescale 1ns/10ps
`include "usx_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// (RULE_01) exch_add_sub low half: first.lo minus second.hi
// (RULE_02) exch_add_sub high half: first.hi plus second.lo
// (RULE_03) exch_add_sub ge: diff nonnegative low, carry high
// (RULE_04) exch_sub_add low half: first.lo plus second.hi
// (RULE_05) exch_sub_add high half: first.hi minus second.lo
// (RULE_06) exch_sub_add ge: carry low, diff nonnegative high
// (RULE_07) half_add_16: halfword lane sums halved
// (RULE_08) half_add_8: byte lane sums halved
// (RULE_09) half_exch_add_sub high: halved first.hi plus second.lo
// (RULE_10) half_exch_add_sub low: halved first.lo minus second.hi
// (RULE_11) half_exch_sub_add high: halved first.hi minus second.lo
// (RULE_12) half_exch_sub_add low: halved first.lo plus second.hi
// (RULE_13) half_sub_16: halfword lane differences halved
// (RULE_14) half_sub_8: byte lane differences halved
// (RULE_15) halving operations never touch ge flags
// (RULE_16) omitted destination writes back to first register
// (RULE_17) failed condition writes nothing at all
// (RULE_18) program never names stack pointer or counter
// (RULE_19) halving shifts full-precision carry or borrow
module usx_alu (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // issue from decode
  input  wire usx_pkg::usx_issue_type issue,
  // write-back
  output usx_pkg::usx_wb_type        wb
);

  ////////////////////////////////////////////////////////////////////////////
  // lane operand selection

  logic [15:0] aLo;
  logic [15:0] aHi;
  logic [15:0] bLo;
  logic [15:0] bHi;
  logic [15:0] loA;
  logic [15:0] loB;
  logic [15:0] hiA;
  logic [15:0] hiB;
  logic        loSub;
  logic        hiSub;
  logic        byteMode;
  logic        byteSub;
  logic        isExch;
  logic        isHalving;

  assign aLo = issue.firstOperand[`USX_LO_HI:0];
  assign aHi = issue.firstOperand[`USX_HI_HI:`USX_HI_LO];
  assign bLo = issue.secondOperand[`USX_LO_HI:0];
  assign bHi = issue.secondOperand[`USX_HI_HI:`USX_HI_LO];

  // true for any operation that writes halves and spares the flags
  function automatic logic usx_is_halving(input usx_pkg::usx_op_type op);
    case (op)
      usx_pkg::USX_OP_EXCH_ADD_SUB: usx_is_halving = 1'b0;
      usx_pkg::USX_OP_EXCH_SUB_ADD: usx_is_halving = 1'b0;
      default:                      usx_is_halving = 1'b1;
    endcase
  endfunction

  // exchange forms cross the halfwords of the second operand
  always_comb begin
    isExch    = 1'b0;
    byteMode  = 1'b0;
    byteSub   = 1'b0;
    loSub     = 1'b0;
    hiSub     = 1'b0;
    isHalving = usx_is_halving(issue.op);
    case (issue.op)
      usx_pkg::USX_OP_EXCH_ADD_SUB,
      usx_pkg::USX_OP_HALF_EXCH_ADD_SUB: begin
        isExch = 1'b1;
        loSub  = 1'b1; // [RULE_01] [RULE_10]
        hiSub  = 1'b0; // [RULE_02] [RULE_09]
      end
      usx_pkg::USX_OP_EXCH_SUB_ADD,
      usx_pkg::USX_OP_HALF_EXCH_SUB_ADD: begin
        isExch = 1'b1;
        loSub  = 1'b0; // [RULE_04] [RULE_12]
        hiSub  = 1'b1; // [RULE_05] [RULE_11]
      end
      usx_pkg::USX_OP_HALF_SUB_16: begin
        loSub = 1'b1; // [RULE_13]
        hiSub = 1'b1;
      end
      usx_pkg::USX_OP_HALF_ADD_8: begin
        byteMode = 1'b1; // [RULE_08]
      end
      usx_pkg::USX_OP_HALF_SUB_8: begin
        byteMode = 1'b1; // [RULE_14]
        byteSub  = 1'b1;
      end
      default: begin
        loSub = 1'b0; // [RULE_07]
      end
    endcase
  end

  assign loA = aLo;
  assign hiA = aHi;
  assign loB = isExch ? bHi : bLo;
  assign hiB = isExch ? bLo : bHi;

  ////////////////////////////////////////////////////////////////////////////
  // halfword lanes, also reused as the exchange lanes

  logic [16:0] loFull;
  logic [15:0] loHalf;
  logic [16:0] hiFull;
  logic [15:0] hiHalf;

  usx_lane_alu uLaneLo (
    .laneA    (loA),
    .laneB    (loB),
    .doSub    (loSub),
    .byteLane (1'b0),
    .fullRes  (loFull),
    .halfRes  (loHalf)
  );

  usx_lane_alu uLaneHi (
    .laneA    (hiA),
    .laneB    (hiB),
    .doSub    (hiSub),
    .byteLane (1'b0),
    .fullRes  (hiFull),
    .halfRes  (hiHalf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // byte lanes; a separate set keeps the halfword carry chains simple

  logic [31:0] byteRes;

  for (genvar gi = 0; gi < 4; gi++) begin : gByte
    logic [15:0] bHalfOut;
    usx_lane_alu uLaneB (
      .laneA    ({8'h00, issue.firstOperand[gi*8 +: 8]}),
      .laneB    ({8'h00, issue.secondOperand[gi*8 +: 8]}),
      .doSub    (byteSub),
      .byteLane (1'b1),
      .fullRes  (),
      .halfRes  (bHalfOut)
    );
    assign byteRes[gi*8 +: 8] = bHalfOut[7:0]; // [RULE_08] [RULE_14]
  end

  ////////////////////////////////////////////////////////////////////////////
  // result and ge assembly

  logic [31:0] resWord;
  logic [3:0]  geNew;
  logic        loGe;
  logic        hiGe;

  // an unsigned sum reaches 0x10000 exactly when bit 16 is set, and an
  // unsigned difference is non-negative exactly when no borrow shows there
  always_comb begin
    loGe = loSub ? ~loFull[`USX_HALF_W] : loFull[`USX_HALF_W]; // [RULE_03] [RULE_06]
    hiGe = hiSub ? ~hiFull[`USX_HALF_W] : hiFull[`USX_HALF_W]; // [RULE_03] [RULE_06]
    geNew = {(hiGe ? `USX_GE_ALL : `USX_GE_NONE),
             (loGe ? `USX_GE_ALL : `USX_GE_NONE)};
    if (byteMode) begin
      resWord = byteRes;
    end else if (isHalving) begin
      resWord = {hiHalf, loHalf}; // [RULE_07] [RULE_09] [RULE_10] [RULE_11] [RULE_12] [RULE_13]
    end else begin
      resWord = {hiFull[`USX_LO_HI:0], loFull[`USX_LO_HI:0]}; // [RULE_01] [RULE_02] [RULE_04] [RULE_05]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered write-back

  usx_pkg::usx_state_type state_r;
  usx_pkg::usx_state_type state_nxt;
  logic                   doIt;
  logic [3:0]             target;

  // one cycle from issue to write-back; all outputs come from flops
  always_comb begin
    doIt      = issue.valid & issue.condPass; // [RULE_17]
    target    = issue.hasDest ? issue.destReg : issue.firstReg; // [RULE_16]
    state_nxt = state_r;
    state_nxt.wb.regWrite = doIt;
    state_nxt.wb.geWrite  = doIt & ~isHalving; // [RULE_15] [RULE_17]
    state_nxt.wb.badReg   = 1'b0;
    if (doIt) begin
      state_nxt.wb.regIdx  = target;
      state_nxt.wb.regData = resWord;
      // ge holds its last value when not written; halving keeps it
      if (!isHalving) begin
        state_nxt.wb.geFlags = geNew; // [RULE_03] [RULE_06]
      end
      // flag misuse of reserved registers, still performing the write
      state_nxt.wb.badReg = (target == `USX_REG_SP) || (target == `USX_REG_PC) ||
                            (issue.firstReg == `USX_REG_SP) ||
                            (issue.firstReg == `USX_REG_PC); // [RULE_18]
    end
  end

  // state register, cleared on reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r.wb.regWrite <= 1'b0;
      state_r.wb.regIdx   <= `USX_REG_RST;
      state_r.wb.regData  <= `USX_WORD_RST;
      state_r.wb.geWrite  <= 1'b0;
      state_r.wb.geFlags  <= `USX_GE_RST;
      state_r.wb.badReg   <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign wb = state_r.wb;

endmodule

/* File: verilog/usx_defines.svh */
// constants for the unsigned packed exchange and halving datapath
`ifndef USX_DEFINES_SVH
`define USX_DEFINES_SVH
`define USX_WORD_W   32
`define USX_HALF_W   16
`define USX_BYTE_W   8
`define USX_REG_W    4
`define USX_GE_W     4
`define USX_LO_HI    15
`define USX_HI_LO    16
`define USX_HI_HI    31
`define USX_GE_ALL   2'h3
`define USX_GE_NONE  2'h0
`define USX_WORD_RST 32'h0000_0000
`define USX_GE_RST   4'h0
`define USX_REG_RST  4'h0
`define USX_REG_SP   4'hd
`define USX_REG_PC   4'hf
`endif

/* File: verilog/usx_lane_alu.sv */
// one 17-bit unsigned lane adder or subtractor with halving
`timescale 1ns/10ps
`include "usx_defines.svh"
module usx_lane_alu (
  // lane operands, upper bits zero for byte lanes
  input  wire logic [15:0] laneA,
  input  wire logic [15:0] laneB,
  input  wire logic        doSub,
  input  wire logic        byteLane,
  // full-precision and halved results
  output logic [16:0]      fullRes,
  output logic [15:0]      halfRes
);
  // 17 bits keep carry out or borrow sign for the halving shift
  always_comb begin
    if (doSub) begin
      fullRes = {1'b0, laneA} - {1'b0, laneB};
    end else begin
      fullRes = {1'b0, laneA} + {1'b0, laneB};
    end
    // byte lanes take their top bit from bit 8 of the wide result
    if (byteLane) begin
      halfRes = {8'h00, fullRes[`USX_BYTE_W:1]}; // [RULE_19]
    end else begin
      halfRes = fullRes[`USX_HALF_W:1]; // [RULE_19]
    end
  end
endmodule

/* File: verilog/usx_pkg.sv */
// types for the unsigned packed exchange and halving datapath
package usx_pkg;
  // operation selector, one-hot
  typedef enum logic [7:0] {
    USX_OP_EXCH_ADD_SUB      = 8'h01,
    USX_OP_EXCH_SUB_ADD      = 8'h02,
    USX_OP_HALF_ADD_16       = 8'h04,
    USX_OP_HALF_ADD_8        = 8'h08,
    USX_OP_HALF_EXCH_ADD_SUB = 8'h10,
    USX_OP_HALF_EXCH_SUB_ADD = 8'h20,
    USX_OP_HALF_SUB_16       = 8'h40,
    USX_OP_HALF_SUB_8        = 8'h80
  } usx_op_type;

  // one issued instruction from decode
  typedef struct packed {
    logic       valid;
    usx_op_type op;
    logic       condPass;
    logic       hasDest;
    logic [3:0] destReg;
    logic [3:0] firstReg;
    logic [31:0] firstOperand;
    logic [31:0] secondOperand;
  } usx_issue_type;

  // write-back toward the register file and flags
  typedef struct packed {
    logic        regWrite;
    logic [3:0]  regIdx;
    logic [31:0] regData;
    logic        geWrite;
    logic [3:0]  geFlags;
    logic        badReg;
  } usx_wb_type;

  // whole state of the top module
  typedef struct packed {
    usx_wb_type wb;
  } usx_state_type;
endpackage
